// ---- hw/fsb_defs.vh ----
/*
  Constants of the flash status and block-protection block: command codes,
  status field positions, geometry, reset values and timing.
  Assumes it is included by its bare name in every file that needs it.
*/
`ifndef FSB_DEFS_VH
`define FSB_DEFS_VH

// Command opcodes.
`define FSB_CMD_WREN 8'h06
`define FSB_CMD_WRDI 8'h04
`define FSB_CMD_RDSR 8'h05
`define FSB_CMD_WRSR 8'h01
`define FSB_CMD_RDFSR 8'h70
`define FSB_CMD_CLFSR 8'h50
`define FSB_CMD_PP4 8'h12
`define FSB_CMD_SE4 8'hDC
`define FSB_CMD_SSE32 8'h5C
`define FSB_CMD_SSE4 8'h21
`define FSB_CMD_BE 8'hC7

// Serial bit counts at which a command is complete.
`define FSB_BITS_OP 9'h008
`define FSB_BITS_WRSR 9'h010
`define FSB_BITS_ADDR 9'h028
`define FSB_BITS_PROG 9'h030
`define FSB_BIT_OP_LAST 9'h007
`define FSB_BIT_WRSR_LAST 9'h00F
`define FSB_BIT_SAT 9'h1FF

// Status register field positions.
`define FSB_SR_BUSY 0
`define FSB_SR_WEL 1
`define FSB_SR_RANGE0 2
`define FSB_SR_RANGE2 4
`define FSB_SR_TB 5
`define FSB_SR_RANGE3 6
`define FSB_SR_SRWD 7
`define FSB_SR_RESET 8'h00

// Flag status register field positions.
`define FSB_FS_ADDR4 0
`define FSB_FS_PROT 1
`define FSB_FS_PGM_ERR 4
`define FSB_FS_ERS_ERR 5
`define FSB_FS_READY 7

// Geometry: sector number sits in address bits 25:16.
`define FSB_SECT_MSB 25
`define FSB_SECT_LSB 16
`define FSB_SECT_COUNT 11'h400
`define FSB_RANGE_FULL 4'hB

// Operation kinds shown on the array strobe.
`define FSB_OP_PROG 3'h1
`define FSB_OP_SE64 3'h2
`define FSB_OP_SE32 3'h3
`define FSB_OP_SE4 3'h4
`define FSB_OP_BULK 3'h5
`define FSB_OP_WRSR 3'h6

// Timing: clock period and the internal cycle time of a write or erase.
`define FSB_CLK_PERIOD_NS 50
`define FSB_T_BUSY_NS 2000

`endif

// ---- hw/fsb_core.v ----
/*
  Status register and block-protection logic of a serial flash, with a
  mode-0 serial slave that takes the register and array commands.
  Assumes the serial clock, select, data and write-protect pins come from
  outside the clock domain, and that an array controller acts on o_op_start.
*/
`timescale 1ns/10ps
`include "fsb_defs.vh"

module fsb_core #(
  parameter BUSY_CYC = `FSB_T_BUSY_NS / `FSB_CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst_n,
  // Serial pins from the host.
  input wire i_sck,
  input wire i_cs_n,
  input wire i_mosi,
  input wire i_wp_n,
  // Serial data back to the host.
  output wire o_miso,
  output wire o_miso_oe,
  // Array operation strobe.
  output reg o_op_start,
  output reg [2:0] o_op_kind,
  output reg [31:0] o_op_addr,
  // Observed state.
  output wire [7:0] o_status,
  output wire [7:0] o_flag_status
);

  // Pin synchronisers: three stages each; clock, select and write-protect levels count when 2 and 3 agree.
  reg [2:0] sck_sy_ff, cs_sy_ff, mosi_sy_ff, wp_sy_ff;
  reg sck_ff, cs_n_ff, wp_n_ff;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sck_sy_ff <= 3'h0;
      cs_sy_ff <= 3'h7;
      mosi_sy_ff <= 3'h0;
      wp_sy_ff <= 3'h7;
      sck_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      wp_n_ff <= 1'b1;
    end else begin
      sck_sy_ff <= {sck_sy_ff[1:0], i_sck};
      cs_sy_ff <= {cs_sy_ff[1:0], i_cs_n};
      mosi_sy_ff <= {mosi_sy_ff[1:0], i_mosi};
      wp_sy_ff <= {wp_sy_ff[1:0], i_wp_n};
      if (sck_sy_ff[1] == sck_sy_ff[2])
        sck_ff <= sck_sy_ff[2];
      if (cs_sy_ff[1] == cs_sy_ff[2])
        cs_n_ff <= cs_sy_ff[2];
      if (wp_sy_ff[1] == wp_sy_ff[2])
        wp_n_ff <= wp_sy_ff[2];
    end
  end

  // Edge strobes on the filtered levels.
  wire nxt_sck = (sck_sy_ff[1] == sck_sy_ff[2]) ? sck_sy_ff[2] : sck_ff;
  wire nxt_cs_n = (cs_sy_ff[1] == cs_sy_ff[2]) ? cs_sy_ff[2] : cs_n_ff;
  wire sck_rise = nxt_sck & ~sck_ff & ~cs_n_ff;
  wire sck_fall = ~nxt_sck & sck_ff & ~cs_n_ff;
  wire cs_fall = ~nxt_cs_n & cs_n_ff;
  wire cs_rise = nxt_cs_n & ~cs_n_ff;
  // MOSI is taken from the third stage, in step with the clock edge seen there.
  wire mosi_bit = mosi_sy_ff[2];

  // Register state.
  reg srwd_ff, tb_ff, wel_ff;
  reg [3:0] protect_range_ff;
  // Reset image of the status byte; bits 1:0 are the volatile latch and busy.
  localparam [7:0] SR_RST = `FSB_SR_RESET;
  reg busy_ff;
  reg [15:0] busy_cnt_ff;
  reg prot_err_ff, pgm_err_ff, ers_err_ff;

  // Status byte layout; busy and ready are one flop so they never disagree.
  assign o_status = {srwd_ff, protect_range_ff[3], tb_ff, protect_range_ff[2:0],
                     wel_ff, busy_ff};
  assign o_flag_status = {~busy_ff, 1'b0, ers_err_ff, pgm_err_ff, 2'b00,
                          prot_err_ff, 1'b1};

  // Serial shift state.
  reg [8:0] bit_cnt_ff;
  reg [7:0] sh_in_ff;
  reg [7:0] cmd_ff;
  reg [31:0] addr_ff;
  reg [7:0] wr_data_ff;
  reg [7:0] sh_out_ff;
  reg rd_en_ff;

  // Read data: the byte repeats so the host may poll status continuously.
  wire [7:0] rd_byte = (cmd_ff == `FSB_CMD_RDFSR) ? o_flag_status : o_status;

  // Input shifting on rising serial clock, output shifting on the falling one.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bit_cnt_ff <= 9'h000;
      sh_in_ff <= 8'h00;
      cmd_ff <= 8'h00;
      addr_ff <= 32'h0000_0000;
      wr_data_ff <= 8'h00;
      sh_out_ff <= 8'h00;
      rd_en_ff <= 1'b0;
    end else begin
      if (cs_fall) begin
        bit_cnt_ff <= 9'h000;
        rd_en_ff <= 1'b0;
      end else if (sck_rise) begin
        sh_in_ff <= {sh_in_ff[6:0], mosi_bit};
        // Saturate so an over-long frame cannot wrap into a valid count.
        if (bit_cnt_ff != `FSB_BIT_SAT)
          bit_cnt_ff <= bit_cnt_ff + 9'h001;
        if (bit_cnt_ff == `FSB_BIT_OP_LAST)
          cmd_ff <= {sh_in_ff[6:0], mosi_bit};
        if (bit_cnt_ff >= `FSB_BITS_OP && bit_cnt_ff < `FSB_BITS_ADDR)
          addr_ff <= {addr_ff[30:0], mosi_bit};
        if (bit_cnt_ff == `FSB_BIT_WRSR_LAST)
          wr_data_ff <= {sh_in_ff[6:0], mosi_bit};
      end else if (sck_fall) begin
        if (bit_cnt_ff >= `FSB_BITS_OP && bit_cnt_ff[2:0] == 3'h0 &&
            (cmd_ff == `FSB_CMD_RDSR || cmd_ff == `FSB_CMD_RDFSR)) begin
          sh_out_ff <= rd_byte;
          rd_en_ff <= 1'b1;
        end else begin
          sh_out_ff <= {sh_out_ff[6:0], 1'b0};
        end
      end
      if (cs_rise)
        rd_en_ff <= 1'b0;
    end
  end

  assign o_miso = sh_out_ff[7];
  assign o_miso_oe = rd_en_ff & ~cs_n_ff;

  // Protected range of the addressed sector.
  wire [9:0] sect = addr_ff[`FSB_SECT_MSB:`FSB_SECT_LSB];
  wire [10:0] span = (protect_range_ff == 4'h0) ? 11'h000 :
                     (11'h001 << (protect_range_ff - 4'h1));
  wire range_all = (protect_range_ff >= `FSB_RANGE_FULL);
  wire top_hit = ({1'b0, sect} >= (`FSB_SECT_COUNT - span));
  wire bot_hit = ({1'b0, sect} < span);
  wire sect_prot = (protect_range_ff != 4'h0) &
                   (range_all | (tb_ff ? bot_hit : top_hit));

  // Command decode at deselect; only complete frames are acted on.
  wire bits_op = (bit_cnt_ff == `FSB_BITS_OP);
  wire bits_addr = (bit_cnt_ff == `FSB_BITS_ADDR);
  wire is_wrsr = (cmd_ff == `FSB_CMD_WRSR) & (bit_cnt_ff == `FSB_BITS_WRSR);
  wire is_prog = (cmd_ff == `FSB_CMD_PP4) & (bit_cnt_ff >= `FSB_BITS_PROG);
  wire is_ers = bits_addr & (cmd_ff == `FSB_CMD_SE4 | cmd_ff == `FSB_CMD_SSE32 |
                             cmd_ff == `FSB_CMD_SSE4);
  wire is_bulk = bits_op & (cmd_ff == `FSB_CMD_BE);
  wire hw_locked = srwd_ff & ~wp_n_ff;
  wire go = cs_rise & ~busy_ff & wel_ff;
  wire arr_prot = is_bulk ? (protect_range_ff != 4'h0) : sect_prot;
  wire arr_go = go & (is_prog | is_ers | is_bulk);
  wire arr_ok = arr_go & ~arr_prot;
  wire wrsr_ok = go & is_wrsr & ~hw_locked;

  reg [2:0] nxt_kind;
  always @* begin
    case (cmd_ff)
      `FSB_CMD_PP4: nxt_kind = `FSB_OP_PROG;
      `FSB_CMD_SE4: nxt_kind = `FSB_OP_SE64;
      `FSB_CMD_SSE32: nxt_kind = `FSB_OP_SE32;
      `FSB_CMD_SSE4: nxt_kind = `FSB_OP_SE4;
      `FSB_CMD_BE: nxt_kind = `FSB_OP_BULK;
      default: nxt_kind = `FSB_OP_WRSR;
    endcase
  end

  // Register updates, the busy timer and the array strobe.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      {srwd_ff, protect_range_ff[3], tb_ff, protect_range_ff[2:0], wel_ff} <=
        SR_RST[7:1];
      busy_ff <= 1'b0;
      busy_cnt_ff <= 16'h0000;
      prot_err_ff <= 1'b0;
      pgm_err_ff <= 1'b0;
      ers_err_ff <= 1'b0;
      o_op_start <= 1'b0;
      o_op_kind <= 3'h0;
      o_op_addr <= 32'h0000_0000;
    end else begin
      o_op_start <= 1'b0;
      // Busy runs a fixed time, then clears the latch with it.
      if (busy_ff) begin
        if (busy_cnt_ff == 16'h0001) begin
          busy_ff <= 1'b0;
          wel_ff <= 1'b0;
        end
        busy_cnt_ff <= busy_cnt_ff - 16'h0001;
      end
      if (cs_rise && !busy_ff) begin
        if (bits_op && cmd_ff == `FSB_CMD_WREN)
          wel_ff <= 1'b1;
        if (bits_op && cmd_ff == `FSB_CMD_WRDI)
          wel_ff <= 1'b0;
        // Errors are only set at deselect, so a clear cannot meet a set.
        if (bits_op && cmd_ff == `FSB_CMD_CLFSR) begin
          prot_err_ff <= 1'b0;
          pgm_err_ff <= 1'b0;
          ers_err_ff <= 1'b0;
        end
      end
      if (wrsr_ok) begin
        srwd_ff <= wr_data_ff[`FSB_SR_SRWD];
        tb_ff <= wr_data_ff[`FSB_SR_TB];
        protect_range_ff <= {wr_data_ff[`FSB_SR_RANGE3],
                             wr_data_ff[`FSB_SR_RANGE2:`FSB_SR_RANGE0]};
      end
      if (wrsr_ok || arr_ok) begin
        busy_ff <= 1'b1;
        busy_cnt_ff <= BUSY_CYC[15:0];
        o_op_start <= 1'b1;
        o_op_kind <= wrsr_ok ? `FSB_OP_WRSR : nxt_kind;
        o_op_addr <= addr_ff;
      end
      // A refused array command starts nothing, stays ready, sets its error flags and drops the latch.
      if (arr_go && arr_prot) begin
        prot_err_ff <= 1'b1;
        if (is_prog)
          pgm_err_ff <= 1'b1;
        else
          ers_err_ff <= 1'b1;
        wel_ff <= 1'b0;
      end
    end
  end

endmodule // fsb_core

// ---- testbench/fsb_core_sva.sv ----
/*
  Checker for the status and protect block, on the core's ports only.
  Assumes one clock domain and the BUSY_CYC handed on by the bind.
*/
`timescale 1ns/10ps
module fsb_core_sva #(
  parameter BUSY_CYC = 40
) (
  // Watched ports.
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire o_op_start,
  input wire [2:0] o_op_kind,
  input wire [7:0] o_status,
  input wire [7:0] o_flag_status
);
  int busy_cnt_ff;
  // Busy length is counted here, as a repetition cannot take a parameter.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) busy_cnt_ff <= 0;
    else busy_cnt_ff <= o_status[0] ? busy_cnt_ff + 1 : 0;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  AST_BUSY_INV: assert property (o_status[0] == !o_flag_status[7])
    else $error("busy and ready disagree");
  AST_START_BUSY: assert property (o_op_start |-> o_status[0])
    else $error("start without busy");
  AST_BUSY_CAUSE: assert property ($rose(o_status[0]) |-> o_op_start)
    else $error("busy without start");
  AST_BUSY_LEN: assert property ($fell(o_status[0]) |-> busy_cnt_ff == BUSY_CYC)
    else $error("busy length wrong");
  AST_WEL_END: assert property ($fell(o_status[0]) |-> !o_status[1])
    else $error("write enable left set");
  AST_START_WEL: assert property (o_op_start |-> o_status[1])
    else $error("start without write enable");
  AST_BULK_FREE: assert property (o_op_start && o_op_kind == 3'h5 |->
    o_status[6] == 1'b0 && o_status[4:2] == 3'h0) else $error("bulk erase while protected");
  AST_PULSE: assert property (o_op_start |=> !o_op_start)
    else $error("start longer than one cycle");
  AST_PROT_IDLE: assert property ($rose(o_flag_status[1]) |-> !o_status[0])
    else $error("protected operation went busy");
  AST_NV_QUIET: assert property (!$stable(o_status[7:2]) |-> o_status[0] || $past(o_status[0]))
    else $error("status bits changed outside a write");
  COV_BULK: cover property (o_op_start && o_op_kind == 3'h5);
  COV_WRSR: cover property (o_op_start && o_op_kind == 3'h6);
  COV_PROT: cover property ($rose(o_flag_status[1]));
endmodule // fsb_core_sva

bind fsb_core fsb_core_sva #(.BUSY_CYC(BUSY_CYC)) u_sva (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .o_op_start(o_op_start), .o_op_kind(o_op_kind),
  .o_status(o_status), .o_flag_status(o_flag_status));

// ---- testbench/fsb_host_model.sv ----
/*
  Host model: sends mode-0 serial frames, MSB first, at a 400 ns bit time.
  Assumes a 50 ns bench clock; the caller orders the commands.
*/
`timescale 1ns/10ps
module fsb_host_model (
  // Bench clock.
  input wire i_clk,
  // Serial pins.
  input wire i_miso,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi
);
  // Idle with the clock low and the device deselected.
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // One frame; the last eight bits seen on the return line are kept.
  task automatic xfer(input logic [47:0] d, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      o_mosi = d[i];
      repeat (4) @(negedge i_clk);
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
      rd = {rd[6:0], i_miso};  // Late in the high phase, past the resync delay.
      o_sck = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi;  // A released line must not show the old bit.
    repeat (8) @(negedge i_clk);
  endtask
endmodule // fsb_host_model

// ---- testbench/tb.sv ----
/*
  Testbench of the status and protect core, driven through the host model.
  Assumes the core's ports and a short busy time of four cycles.
*/
`timescale 1ns/10ps
module tb;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wp_n = 1'b1;
  wire sck, cs_n, mosi, miso, op_start, miso_oe;
  // A released return line shows the inverse of its last bit, so a late drive is caught.
  wire miso_bus = miso_oe ? miso : ~miso;
  wire [2:0] op_kind;
  wire [31:0] op_addr;
  wire [7:0] st, fst;
  int n_errors = 0;
  int checks = 0;
  int n_ops = 0;
  logic [2:0] last_kind;
  logic [31:0] last_addr;
  logic [7:0] rd;
  // Free-running system clock.
  always #25 i_sys_clk = ~i_sys_clk;
  fsb_host_model host (.i_clk(i_sys_clk), .i_miso(miso_bus), .o_sck(sck), .o_cs_n(cs_n),
    .o_mosi(mosi));
  fsb_core #(.BUSY_CYC(4)) uut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sck(sck),
    .i_cs_n(cs_n), .i_mosi(mosi), .i_wp_n(i_wp_n), .o_miso(miso), .o_miso_oe(miso_oe),
    .o_op_start(op_start), .o_op_kind(op_kind), .o_op_addr(op_addr), .o_status(st),
    .o_flag_status(fst));
  // Records every started operation for the tests to judge.
  always @(posedge i_sys_clk) begin
    if (op_start === 1'b1) begin
      n_ops <= n_ops + 1;
      last_kind <= op_kind;
      last_addr <= op_addr;
    end
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmd(input logic [47:0] d, input int nb);
    host.xfer(d, nb, rd);
  endtask
  // Bounded wait: a write that never ends must not hang the run.
  task automatic settle();
    for (int k = 0; k < 200 && st[0] !== 1'b0; k++) @(negedge i_sys_clk);
    chk("busy", st[0], 1'b0);
  endtask
  task automatic wsr(input logic [7:0] v);
    cmd(8'h06, 8);
    cmd({8'h01, v}, 16);
    settle();
    chk("status write", st, {v[7:2], 2'b00});
    chk("write kind", last_kind, 3'h6);
  endtask
  // One protected-or-not operation; the expectation comes from the range table.
  task automatic op(input logic [7:0] c, input int s, input logic t, input logic [3:0] b);
    logic [31:0] a;
    logic p;
    logic [5:0] ef;
    int n0, nb, lim;
    a = {6'h00, s[9:0], 16'hF000};
    lim = b == 0 ? 0 : b > 10 ? 1024 : 1 << (b - 1);
    p = c == 8'hC7 ? b != 0 : t ? s[9:0] < lim : s[9:0] >= 1024 - lim;
    ef = !p ? 6'h01 : c == 8'h12 ? 6'h13 : 6'h23;
    nb = c == 8'h12 ? 48 : c == 8'hC7 ? 8 : 40;
    n0 = n_ops;
    cmd(8'h06, 8);
    cmd({c, a, 8'hA5} >> (48 - nb), nb);
    settle();
    chk("started", n_ops - n0, !p);
    if (!p) chk("kind", last_kind, c == 8'h12 ? 1 : c == 8'hDC ? 2 : c == 8'h5C ? 3 : c == 8'h21 ? 4 : 5);
    if (!p && c != 8'hC7) chk("addr", last_addr, a);
    chk("flags", fst[5:0], ef);
    host.xfer({8'h70, 8'h00}, 16, rd);
    chk("read flags", rd, {2'b10, ef});
    cmd(8'h50, 8);
  endtask
  task automatic t_reset();
    chk("status", st, 8'h00);
    chk("flag status", fst, 8'h81);
    host.xfer({8'h05, 8'h00}, 16, rd);
    chk("read status", rd, 8'h00);
    chk("miso released", miso_oe, 1'b0);
    cmd(8'h06, 8);
    host.xfer({8'h05, 8'h00}, 16, rd);
    chk("enable latch", rd, 8'h02);
    cmd(8'h04, 8);
    host.xfer({8'h05, 8'h00}, 16, rd);
    chk("disable latch", rd, 8'h00);
    cmd({8'hDC, 32'h0}, 40);
    chk("no enable", n_ops, 0);
    $display("test reset done");
  endtask
  task automatic t_lock();
    wsr(8'h80);
    i_wp_n = 1'b0;
    cmd(8'h06, 8);
    cmd({8'h01, 8'h1C}, 16);
    settle();
    host.xfer({8'h05, 8'h00}, 16, rd);
    chk("locked", rd, 8'h82);
    i_wp_n = 1'b1;
    repeat (8) @(negedge i_sys_clk);
    cmd({8'h01, 8'h00}, 16);
    settle();
    chk("unlocked", st, 8'h00);
    $display("test lock done");
  endtask
  task automatic t_prot();
    logic [3:0] b;
    int lim;
    for (int t = 0; t < 2; t++) begin
      for (int j = 0; j < 7; j++) begin
        b = 4'(28'hFBA5210 >> (4 * j));
        lim = b == 0 ? 0 : b > 10 ? 1024 : 1 << (b - 1);
        wsr({1'b0, b[3], t[0], b[2:0], 2'b00});
        op(8'hDC, t ? lim - 1 : 1024 - lim, t[0], b);
        op(j % 3 == 0 ? 8'h12 : j % 3 == 1 ? 8'h5C : 8'h21, t ? lim : 1023 - lim, t[0], b);
        op(8'hC7, 0, t[0], b);
      end
    end
    $display("test protect done");
  endtask
  // Main sequence after two reset cycles.
  initial begin
    repeat (2) @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_lock();
    t_prot();
    final_report();
  end
  // Watchdog: the tests need well under 60000 cycles.
  initial begin
    #3000000;
    n_errors++;
    final_report();
  end
endmodule // tb
